// [logic/atlm_axis_limit.sv]
// module: per-axis travel limit monitor with hard switch and soft bound checks
`timescale 1ns/1ps
module atlm_axis_limit
  import atlm_pkg::*;
#(
  parameter int PW = POS_WIDTH,
  parameter int VW = VEL_WIDTH
) (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 config_load,
  input  wire logic                 enable_positive_bound,
  input  wire logic                 enable_negative_bound,
  input  wire logic                 enable_both_bounds,
  input  wire logic                 response_drive_off,
  input  wire logic                 response_hard_stop,
  input  wire logic                 response_decel_stop,
  input  wire logic                 switch_polarity_invert,
  input  wire logic                 soft_enable_high,
  input  wire logic                 soft_enable_low,
  input  wire logic                 soft_enable_both,
  input  wire logic                 soft_response_drive_off,
  input  wire logic                 soft_response_hard_stop,
  input  wire logic                 soft_response_decel_stop,
  input  wire logic signed [PW-1:0] soft_high_bound,
  input  wire logic signed [PW-1:0] soft_low_bound,
  input  wire logic        [VW-1:0] decel_step,
  input  wire logic                 axis_enable,
  input  wire logic                 axis_disable,
  input  wire logic                 limit_pos_pin,
  input  wire logic                 limit_neg_pin,
  input  wire logic signed [PW-1:0] target_position,
  input  wire logic                 target_valid,
  input  wire logic signed [VW-1:0] commanded_velocity,
  output logic                      drive_enable,
  output logic signed      [VW-1:0] velocity_out,
  output logic                      motion_halted,
  output logic                      decelerating,
  output logic                      pos_switch_level,
  output logic                      neg_switch_level,
  output logic                      pos_switch_input_state,
  output logic                      neg_switch_input_state,
  output logic                      pos_switch_tripped,
  output logic                      neg_switch_tripped,
  output logic                      high_soft_bound_tripped,
  output logic                      low_soft_bound_tripped,
  output logic                      axis_error_flag
);

  // ==========================================================================
  // configuration
  atlm_cfg_type         cfg;
  atlm_cfg_type         next_cfg;
  logic signed [PW-1:0] hi_bound;
  logic signed [PW-1:0] next_hi_bound;
  logic signed [PW-1:0] lo_bound;
  logic signed [PW-1:0] next_lo_bound;
  logic        [VW-1:0] step;
  logic        [VW-1:0] next_step;

  always_comb begin
    next_cfg      = cfg;
    next_hi_bound = hi_bound;
    next_lo_bound = lo_bound;
    next_step     = step;
    if (config_load) begin
      next_cfg.pos_en     = enable_positive_bound;
      next_cfg.neg_en     = enable_negative_bound;
      next_cfg.both_en    = enable_both_bounds;
      next_cfg.off        = response_drive_off;
      next_cfg.hard       = response_hard_stop;
      next_cfg.decel      = response_decel_stop;
      next_cfg.invert     = switch_polarity_invert;
      next_cfg.hi_en      = soft_enable_high;
      next_cfg.lo_en      = soft_enable_low;
      next_cfg.soft_both  = soft_enable_both;
      next_cfg.soft_off   = soft_response_drive_off;
      next_cfg.soft_hard  = soft_response_hard_stop;
      next_cfg.soft_decel = soft_response_decel_stop;
      next_hi_bound       = soft_high_bound;
      next_lo_bound       = soft_low_bound;
      next_step           = decel_step;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg      <= CFG_RESET;
      hi_bound <= '0;
      lo_bound <= '0;
      step     <= '0;
    end else begin
      cfg      <= next_cfg;
      hi_bound <= next_hi_bound;
      lo_bound <= next_lo_bound;
      step     <= next_step;
    end
  end

  logic pos_en;
  logic neg_en;
  logic hi_en;
  logic lo_en;
  assign pos_en = cfg.pos_en | cfg.both_en;
  assign neg_en = cfg.neg_en | cfg.both_en;
  assign hi_en  = cfg.hi_en | cfg.soft_both;
  assign lo_en  = cfg.lo_en | cfg.soft_both;

  // ==========================================================================
  // switch input synchronisers and edge detect
  logic pos_meta;
  logic neg_meta;
  logic pos_sync;
  logic neg_sync;
  logic pos_chk_q;
  logic neg_chk_q;
  logic pos_act;
  logic neg_act;
  logic pos_chk;
  logic neg_chk;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pos_meta  <= ~RAW_ACTIVE_LEVEL;
      neg_meta  <= ~RAW_ACTIVE_LEVEL;
      pos_sync  <= ~RAW_ACTIVE_LEVEL;
      neg_sync  <= ~RAW_ACTIVE_LEVEL;
      pos_chk_q <= 1'b0;
      neg_chk_q <= 1'b0;
    end else begin
      pos_meta  <= limit_pos_pin;
      neg_meta  <= limit_neg_pin;
      pos_sync  <= pos_meta;
      neg_sync  <= neg_meta;
      pos_chk_q <= pos_chk;
      neg_chk_q <= neg_chk;
    end
  end

  assign pos_act = cfg.invert ? (pos_sync != RAW_ACTIVE_LEVEL)
                              : (pos_sync == RAW_ACTIVE_LEVEL);
  assign neg_act = cfg.invert ? (neg_sync != RAW_ACTIVE_LEVEL)
                              : (neg_sync == RAW_ACTIVE_LEVEL);
  assign pos_chk = pos_en & pos_act;
  assign neg_chk = neg_en & neg_act;

  // ==========================================================================
  // trip events and chosen response
  logic          pos_ev;
  logic          neg_ev;
  logic          hi_ev;
  logic          lo_ev;
  logic          hw_fire;
  logic          sw_fire;
  atlm_resp_type hw_resp;
  atlm_resp_type sw_resp;
  atlm_resp_type stop_resp;

  assign pos_ev  = pos_chk & ~pos_chk_q;
  assign neg_ev  = neg_chk & ~neg_chk_q;
  assign hi_ev   = target_valid & hi_en & (target_position > hi_bound);
  assign lo_ev   = target_valid & lo_en & (target_position < lo_bound);
  assign hw_fire = pos_ev | neg_ev;
  assign sw_fire = hi_ev | lo_ev;
  assign hw_resp = resp_pick(cfg.off, cfg.hard, cfg.decel);
  assign sw_resp = resp_pick(cfg.soft_off, cfg.soft_hard, cfg.soft_decel);

  always_comb begin
    if ((hw_fire && hw_resp == RESP_OFF) || (sw_fire && sw_resp == RESP_OFF)) begin
      stop_resp = RESP_OFF;
    end else if ((hw_fire && hw_resp == RESP_HARD) || (sw_fire && sw_resp == RESP_HARD)) begin
      stop_resp = RESP_HARD;
    end else if ((hw_fire && hw_resp == RESP_DECEL) ||
                 (sw_fire && sw_resp == RESP_DECEL)) begin
      stop_resp = RESP_DECEL;
    end else begin
      stop_resp = RESP_NONE;
    end
  end

  // ==========================================================================
  // axis state and velocity path
  atlm_state_type       state;
  atlm_state_type       next_state;
  atlm_state_type       base_state;
  logic signed [VW-1:0] next_velocity;
  logic                 next_drive;

  atlm_ramp_if #(.VW(VW)) rp ();
  atlm_decel_ramp #(.VW(VW)) u_ramp (
    .clock  (clock),
    .resetn (resetn),
    .rp     (rp.ramp)
  );

  always_comb begin
    base_state = state;
    if (axis_enable) base_state = ST_RUN;
    if (axis_disable) base_state = ST_OFF;
    if (base_state == ST_DECEL && rp.done) base_state = ST_HALT;
    next_state = base_state;
    case (stop_resp)
      RESP_OFF:   next_state = ST_OFF;
      RESP_HARD:  if (base_state != ST_OFF) next_state = ST_HALT;
      RESP_DECEL: if (base_state == ST_RUN) next_state = ST_DECEL;
      default:    next_state = base_state;
    endcase
    next_drive = (next_state != ST_OFF);
    case (state)
      ST_RUN:   next_velocity = commanded_velocity;
      ST_DECEL: next_velocity = rp.velocity;
      default:  next_velocity = '0;
    endcase
  end

  assign rp.start          = (next_state == ST_DECEL) && (state != ST_DECEL);
  assign rp.start_velocity = velocity_out;
  assign rp.step           = step;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state        <= ST_OFF;
      drive_enable <= 1'b0;
      velocity_out <= '0;
    end else begin
      state        <= next_state;
      drive_enable <= next_drive;
      velocity_out <= next_velocity;
    end
  end

  assign motion_halted = (state == ST_HALT);
  assign decelerating  = (state == ST_DECEL);

  // ==========================================================================
  // sticky flags: an event in the enable cycle keeps its flag set
  logic next_pos_trip;
  logic next_neg_trip;
  logic next_hi_trip;
  logic next_lo_trip;
  logic next_error;

  always_comb begin
    next_pos_trip = (pos_switch_tripped & ~axis_enable) | pos_ev;
    next_neg_trip = (neg_switch_tripped & ~axis_enable) | neg_ev;
    next_hi_trip  = (high_soft_bound_tripped & ~axis_enable) | hi_ev;
    next_lo_trip  = (low_soft_bound_tripped & ~axis_enable) | lo_ev;
    next_error    = (axis_error_flag & ~axis_enable) | hw_fire | sw_fire;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pos_switch_tripped      <= FLAG_RESET;
      neg_switch_tripped      <= FLAG_RESET;
      high_soft_bound_tripped <= FLAG_RESET;
      low_soft_bound_tripped  <= FLAG_RESET;
      axis_error_flag         <= FLAG_RESET;
    end else begin
      pos_switch_tripped      <= next_pos_trip;
      neg_switch_tripped      <= next_neg_trip;
      high_soft_bound_tripped <= next_hi_trip;
      low_soft_bound_tripped  <= next_lo_trip;
      axis_error_flag         <= next_error;
    end
  end

  assign pos_switch_level       = pos_act;
  assign neg_switch_level       = neg_act;
  assign pos_switch_input_state = pos_sync;
  assign neg_switch_input_state = neg_sync;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [VW-1:0] vel_mag;
  assign vel_mag = velocity_out[VW-1] ? VW'(-velocity_out) : VW'(velocity_out);

  pos_only_cfg_a: assert property (config_load && enable_positive_bound &&
      !enable_negative_bound && !enable_both_bounds |=> pos_en && !neg_en)
    else $error("positive bound not enabled alone");
  both_cfg_a: assert property (config_load && enable_both_bounds |=>
      pos_en && neg_en)
    else $error("both bounds setting failed");
  drive_off_a: assert property (stop_resp == RESP_OFF |=> !drive_enable[*2])
    else $error("drive not cut on trip");
  hard_stop_a: assert property (stop_resp == RESP_HARD && !axis_disable &&
      (state != ST_OFF || axis_enable) |=> motion_halted ##1 velocity_out == '0)
    else $error("hard stop did not halt");
  decel_ramp_a: assert property ((state == ST_DECEL)[*3] |->
      vel_mag <= $past(vel_mag))
    else $error("velocity grew while decelerating");
  polarity_a: assert property (cfg.invert && pos_en && !pos_chk_q &&
      pos_switch_input_state != RAW_ACTIVE_LEVEL && !axis_enable |=> pos_switch_tripped)
    else $error("inverted switch did not trip");
  trip_hold_a: assert property (pos_switch_tripped && !axis_enable |=>
      pos_switch_tripped && axis_error_flag)
    else $error("trip flag dropped without enable");
  live_level_a: assert property (pos_switch_input_state == $past(limit_pos_pin, 2))
    else $error("live input state wrong");
  soft_high_a: assert property (target_valid && hi_en && target_position > hi_bound
      |=> high_soft_bound_tripped && axis_error_flag)
    else $error("high soft bound not flagged");
  soft_resp_a: assert property (lo_ev && !hw_fire && sw_resp == RESP_DECEL &&
      state == ST_RUN && !axis_enable && !axis_disable |=> decelerating)
    else $error("soft decel response not taken");
  soft_hold_a: assert property (low_soft_bound_tripped && !axis_enable |=>
      low_soft_bound_tripped)
    else $error("soft trip flag dropped");
  no_check_a: assert property (!pos_en && !neg_en && !hi_en && !lo_en &&
      !axis_error_flag |=> !axis_error_flag)
    else $error("error raised with checks disabled");

  pos_trip_c: cover property (pos_ev ##1 pos_switch_tripped);
  decel_done_c: cover property (decelerating ##[1:300] motion_halted);
  soft_low_c: cover property (lo_ev ##1 low_soft_bound_tripped);
  reenable_c: cover property (axis_error_flag ##1 axis_enable ##1 !axis_error_flag);

endmodule // atlm_axis_limit

// [logic/atlm_pkg.sv]
// package: shared types and constants for the axis travel limit monitor
package atlm_pkg;

  // ==========================================================================
  // widths and levels
  localparam int   POS_WIDTH        = 32;
  localparam int   VEL_WIDTH        = 24;
  localparam logic RAW_ACTIVE_LEVEL = 1'b0;  // switch pin level that means active
  localparam logic FLAG_RESET       = 1'b0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DECEL, ST_HALT} atlm_state_type;
  typedef enum logic [1:0] {RESP_NONE, RESP_OFF, RESP_HARD, RESP_DECEL} atlm_resp_type;

  typedef struct packed {
    logic pos_en;
    logic neg_en;
    logic both_en;
    logic off;
    logic hard;
    logic decel;
    logic invert;
    logic hi_en;
    logic lo_en;
    logic soft_both;
    logic soft_off;
    logic soft_hard;
    logic soft_decel;
  } atlm_cfg_type;

  localparam atlm_cfg_type CFG_RESET = '0;

  // ==========================================================================
  // strongest selected response wins when several are set
  function automatic atlm_resp_type resp_pick(input logic off, input logic hard,
                                              input logic decel);
    if (off) return RESP_OFF;
    if (hard) return RESP_HARD;
    if (decel) return RESP_DECEL;
    return RESP_NONE;
  endfunction

endpackage

// [logic/atlm_ramp_if.sv]
// interface: link between the limit monitor and its deceleration ramp
`timescale 1ns/1ps
interface atlm_ramp_if #(parameter int VW = 24);
  logic                 start;
  logic signed [VW-1:0] start_velocity;
  logic        [VW-1:0] step;
  logic signed [VW-1:0] velocity;
  logic                 done;

  modport ctrl (output start, output start_velocity, output step,
                input velocity, input done);
  modport ramp (input start, input start_velocity, input step,
                output velocity, output done);
endinterface

// [logic/atlm_decel_ramp.sv]
// module: velocity ramp toward zero by a fixed step per clock
`timescale 1ns/1ps
module atlm_decel_ramp
  import atlm_pkg::*;
#(
  parameter int VW = VEL_WIDTH
) (
  input wire logic clock,
  input wire logic resetn,
  atlm_ramp_if.ramp rp
);

  logic signed [VW-1:0] vel;
  logic signed [VW-1:0] next_vel;
  logic                 active;
  logic                 next_active;
  logic        [VW-1:0] mag;
  logic        [VW-1:0] eff_step;

  // ==========================================================================
  // ramp step
  always_comb begin
    next_vel    = vel;
    next_active = active;
    mag         = vel[VW-1] ? VW'(-vel) : VW'(vel);
    eff_step    = (rp.step == '0) ? VW'(1) : rp.step;  // zero step would never finish
    if (rp.start) begin
      next_vel    = rp.start_velocity;
      next_active = 1'b1;
    end else if (active) begin
      if (vel == '0) begin
        next_active = 1'b0;
      end else if (mag <= eff_step) begin
        next_vel = '0;
      end else if (vel[VW-1]) begin
        next_vel = vel + $signed(eff_step);
      end else begin
        next_vel = vel - $signed(eff_step);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vel    <= '0;
      active <= 1'b0;
    end else begin
      vel    <= next_vel;
      active <= next_active;
    end
  end

  assign rp.velocity = vel;
  assign rp.done     = active && (vel == '0);

endmodule // atlm_decel_ramp

// [verification/atlm_limit_partner.sv]
// model: limit switches and motion generator on the far side of one axis
`timescale 1ns/1ps
module atlm_limit_partner
  import atlm_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        pos_hit,
  input  wire logic                        neg_hit,
  input  wire logic                        normally_closed,
  input  wire logic signed [VEL_WIDTH-1:0] vel_req,
  output logic                             limit_pos_pin,
  output logic                             limit_neg_pin,
  output logic signed      [VEL_WIDTH-1:0] commanded_velocity
);
  // ==========================================================================
  // switch contacts: closed contact pulls low, open contact pulls high
  assign limit_pos_pin = normally_closed ? pos_hit : ~pos_hit;
  assign limit_neg_pin = normally_closed ? neg_hit : ~neg_hit;

  // ==========================================================================
  // generator velocity, registered as the trajectory stage would present it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      commanded_velocity <= '0;
    end else begin
      commanded_velocity <= vel_req;
    end
  end
endmodule // atlm_limit_partner

// [verification/atlm_axis_limit_tb.sv]
// testbench: self-checking bench for the axis travel limit monitor
`timescale 1ns/1ps
module atlm_axis_limit_tb;
  import atlm_pkg::*;

  // ==========================================================================
  // stimulus and observation
  logic                        clock = 1'h0;
  logic                        resetn = 1'h0;
  logic                        config_load = 1'h0;
  logic [12:0]                 cfgv = 13'h0000;
  logic signed [POS_WIDTH-1:0] hb = '0;
  logic signed [POS_WIDTH-1:0] lb = '0;
  logic [VEL_WIDTH-1:0]        step = 24'h000001;
  logic                        axis_enable = 1'h0;
  logic                        axis_disable = 1'h0;
  logic                        pos_hit = 1'h0;
  logic                        neg_hit = 1'h0;
  logic signed [POS_WIDTH-1:0] target = '0;
  logic                        target_valid = 1'h0;
  logic signed [VEL_WIDTH-1:0] vel_req = '0;
  logic                        pin_p, pin_n, de, mh, dc, pt, nt, ht, lt, er, pl, nl, pi, ni;
  logic signed [VEL_WIDTH-1:0] cmd_vel, vel_out;
  logic [15:0]                 st;
  logic                        chk = 1'h0;
  string                       name_q[$];
  logic [15:0]                 exp_q[$];
  int                          err_total = 0;
  int                          tests_run = 0;
  int                          seed = 78;

  always #5 clock = ~clock;

  atlm_limit_partner far_side (.clock(clock), .resetn(resetn), .pos_hit(pos_hit),
    .neg_hit(neg_hit), .normally_closed(cfgv[6]), .vel_req(vel_req),
    .limit_pos_pin(pin_p), .limit_neg_pin(pin_n), .commanded_velocity(cmd_vel));

  atlm_axis_limit dut (.clock(clock), .resetn(resetn), .config_load(config_load),
    .enable_positive_bound(cfgv[12]), .enable_negative_bound(cfgv[11]),
    .enable_both_bounds(cfgv[10]), .response_drive_off(cfgv[9]),
    .response_hard_stop(cfgv[8]), .response_decel_stop(cfgv[7]),
    .switch_polarity_invert(cfgv[6]), .soft_enable_high(cfgv[5]),
    .soft_enable_low(cfgv[4]), .soft_enable_both(cfgv[3]),
    .soft_response_drive_off(cfgv[2]), .soft_response_hard_stop(cfgv[1]),
    .soft_response_decel_stop(cfgv[0]), .soft_high_bound(hb), .soft_low_bound(lb),
    .decel_step(step), .axis_enable(axis_enable), .axis_disable(axis_disable),
    .limit_pos_pin(pin_p), .limit_neg_pin(pin_n), .target_position(target),
    .target_valid(target_valid), .commanded_velocity(cmd_vel), .drive_enable(de),
    .velocity_out(vel_out), .motion_halted(mh), .decelerating(dc),
    .pos_switch_level(pl), .neg_switch_level(nl), .pos_switch_input_state(pi),
    .neg_switch_input_state(ni), .pos_switch_tripped(pt), .neg_switch_tripped(nt),
    .high_soft_bound_tripped(ht), .low_soft_bound_tripped(lt), .axis_error_flag(er));

  // status word: {drive, halted, decel, vel zero} {trips p n hi lo} {error} {levels, inputs}
  assign st = {de, mh, dc, vel_out === '0, pt, nt, ht, lt, er, 3'h0, pl, nl, pi, ni};

  // ==========================================================================
  // comparison and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // monitor: each flagged result is matched with the oldest note
  always @(negedge clock) begin
    if (chk) check(name_q.pop_front(), st, exp_q.pop_front());
  end

  // ==========================================================================
  // drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic expect_st(input string what, input logic [15:0] exp);
    name_q.push_back(what);
    exp_q.push_back(exp);
    chk = 1'h1;
    cyc(1);
    chk = 1'h0;
  endtask

  task automatic cfg(input logic [12:0] c);
    cfgv = c;
    config_load = 1'h1;
    cyc(1);
    config_load = 1'h0;
    cyc(3);
  endtask

  task automatic enable_axis;
    axis_enable = 1'h1;
    cyc(1);
    axis_enable = 1'h0;
    cyc(3);
  endtask

  task automatic send_target(input logic signed [POS_WIDTH-1:0] t);
    target = t;
    target_valid = 1'h1;
    cyc(1);
    target_valid = 1'h0;
    cyc(2);
  endtask

  task automatic wait_stop;
    int n;
    n = 0;
    while (!(mh === 1'h1 || de === 1'h0) && n < 6000) begin
      cyc(1);
      n++;
    end
    check("stop wait", {15'h0000, n < 6000}, 16'h0001);
  endtask

  // ==========================================================================
  // sequence
  logic [12:0] soft_cfg[3] = '{13'h0064, 13'h0052, 13'h0049};

  initial begin
    vel_req = 24'sd64 + VEL_WIDTH'($random(seed) & 32'h00000fff);
    step = 24'h000001 + VEL_WIDTH'($random(seed) & 32'h0000000f);
    hb = $random(seed) & 32'h000003ff;
    lb = -32'sd100;
    repeat (10) @(posedge clock);
    #1;
    resetn = 1'h1;
    cyc(2);
    expect_st("reset state", 16'h1003);
    pos_hit = 1'h1;
    cyc(4);
    expect_st("unconfigured switch", 16'h1009);
    pos_hit = 1'h0;
    cyc(3);
    cfg(13'h1200);
    enable_axis();
    expect_st("run", 16'h8003);
    neg_hit = 1'h1;
    cyc(4);
    expect_st("neg not enabled", 16'h8006);
    pos_hit = 1'h1;
    cyc(5);
    expect_st("pos trip off", 16'h188c);
    pos_hit = 1'h0;
    neg_hit = 1'h0;
    cyc(4);
    expect_st("trip sticky", 16'h1883);
    enable_axis();
    expect_st("re-enable", 16'h8003);
    cfg(13'h0500);
    neg_hit = 1'h1;
    cyc(5);
    expect_st("neg trip hard", 16'hd486);
    neg_hit = 1'h0;
    cyc(4);
    enable_axis();
    cfg(13'h0040);                                  // polarity first, with checks off
    cfg(13'h04c0);
    expect_st("inverted idle", 16'h8000);
    pos_hit = 1'h1;
    cyc(4);
    expect_st("decel entry", 16'ha88a);
    wait_stop();
    expect_st("decel halted", 16'hd88a);
    pos_hit = 1'h0;
    cyc(4);
    enable_axis();
    for (int i = 0; i < 3; i++) begin
      cfg(soft_cfg[i]);
      send_target(hb);
      expect_st("soft bound edge", 16'h8000);
      if (i < 2) begin
        send_target(i == 1 ? hb + 1 : lb - 1);
        expect_st("soft other bound", 16'h8000);
      end
      send_target(i == 0 ? hb + 1 : lb - 1);
      wait_stop();
      expect_st("soft trip", {i == 0 ? 8'h12 : 8'hd1, 8'h80});
      enable_axis();
      expect_st("soft cleared", 16'h8000);
    end
    cfg(13'h0840);
    neg_hit = 1'h1;
    cyc(5);
    expect_st("monitor only", 16'h8485);
    neg_hit = 1'h0;
    enable_axis();
    axis_disable = 1'h1;
    cyc(1);
    axis_disable = 1'h0;
    cyc(2);
    expect_st("disabled", 16'h1000);
    final_report();
  end

  initial begin
    #900us;
    err_total++;
    final_report();
  end
endmodule // atlm_axis_limit_tb
